/* verilog/pfc_flash_ctrl.sv */
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module pfc_flash_ctrl
    import pfc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              RESETN_I,
    input  wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
    input  wire logic              S_AXI_AWVALID_I,
    output logic                   S_AXI_AWREADY_O,
    input  wire logic [31:0]       S_AXI_WDATA_I,
    input  wire logic [3:0]        S_AXI_WSTRB_I,
    input  wire logic              S_AXI_WVALID_I,
    output logic                   S_AXI_WREADY_O,
    output logic [1:0]             S_AXI_BRESP_O,
    output logic                   S_AXI_BVALID_O,
    input  wire logic              S_AXI_BREADY_I,
    input  wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
    input  wire logic              S_AXI_ARVALID_I,
    output logic                   S_AXI_ARREADY_O,
    output logic [31:0]            S_AXI_RDATA_O,
    output logic [1:0]             S_AXI_RRESP_O,
    output logic                   S_AXI_RVALID_O,
    input  wire logic              S_AXI_RREADY_I,
    output logic [ADDR_W-1:0]      PM_ADDR_O,
    output logic                   PM_RD_O,
    input  wire logic [DATA_W-1:0] PM_RDATA_I,
    output logic                   PM_WE_O,
    output logic [DATA_W-1:0]      PM_WDATA_O,
    output logic                   PM_ERASE_O,
    output logic                   NOP_FORCE_O,
    output logic                   CPU_HALT_O,
    output logic                   HIGH_POWER_O,
    input  wire logic [1:0]        WRITE_PROTECT_I,
    input  wire logic              CODE_PROTECT_I,
    input  wire logic              DEBUG_BREAK_I,
    output logic                   EXT_PROG_EN_O
);
    if (PROG_CYCLES < 2) begin : g_bad_cycles
        $error("PROG_CYCLES must be at least 2");
    end
    pfc_state_e         state;
    pfc_unlock_e        ulk;
    logic [3:0]         pin_s1, pin_s2;
    logic [1:0]         write_protect_setting;
    logic               code_protect_fuse, debugger_break;
    logic [4:0]         flash_addr_high;
    logic [7:0]         flash_addr_low;
    logic [5:0]         flash_data_high;
    logic [7:0]         flash_data_low;
    logic               rd_bit, wr_bit, write_enable_bit, erase_sel, latch_only_select;
    logic               op_latch, op_erase;
    logic [ROW_W-1:0]   row;
    logic [IDX_W-1:0]   idx;
    logic [31:0]        timer;
    logic [DATA_W-1:0]  row_buf [ROW_WORDS];
    logic [AXI_AW-1:0]  waddr;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic [31:0]        next_rdata;
    logic [1:0]         next_rresp;
    logic [ADDR_W-1:0]  flash_addr_pair, wp_bound;
    logic               do_wr, wr_hit, wr_ctl, busy, start_wr, start_rd;
    // pins pass two flops before use
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
        end else begin
            pin_s1 <= {DEBUG_BREAK_I, CODE_PROTECT_I, WRITE_PROTECT_I};
            pin_s2 <= pin_s1;
        end
    end
    assign write_protect_setting = pin_s2[1:0];
    assign code_protect_fuse     = pin_s2[2];
    assign debugger_break        = pin_s2[3];
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            EXT_PROG_EN_O <= RST_BIT;
        end else begin
            EXT_PROG_EN_O <= ~code_protect_fuse;
        end
    end
    // axi4-lite write path: address and data in either order
    assign do_wr  = ~S_AXI_AWREADY_O & ~S_AXI_WREADY_O & ~S_AXI_BVALID_O;
    assign wr_hit = do_wr & wstrb[0];
    assign wr_ctl = wr_hit & (waddr == OFS_CONTROL);
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O  <= 1'b1;
            S_AXI_BVALID_O  <= 1'b0;
            S_AXI_BRESP_O   <= RESP_OKAY;
            waddr           <= '0;
            wdata           <= '0;
            wstrb           <= '0;
        end else begin
            if (S_AXI_AWREADY_O && S_AXI_AWVALID_I) begin
                S_AXI_AWREADY_O <= 1'b0;
                waddr           <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WREADY_O && S_AXI_WVALID_I) begin
                S_AXI_WREADY_O <= 1'b0;
                wdata          <= S_AXI_WDATA_I;
                wstrb          <= S_AXI_WSTRB_I;
            end
            if (do_wr) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= (waddr > OFS_STATUS || waddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O  <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O  <= 1'b1;
            end
        end
    end
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_OKAY;
        if (S_AXI_ARADDR_I == OFS_ADDR_LOW) begin
            next_rdata[7:0] = flash_addr_low;
        end else if (S_AXI_ARADDR_I == OFS_ADDR_HIGH) begin
            next_rdata[4:0] = flash_addr_high;
        end else if (S_AXI_ARADDR_I == OFS_DATA_LOW) begin
            next_rdata[7:0] = flash_data_low;
        end else if (S_AXI_ARADDR_I == OFS_DATA_HIGH) begin
            next_rdata[5:0] = flash_data_high;
        end else if (S_AXI_ARADDR_I == OFS_CONTROL) begin
            next_rdata[CTL_RD]    = rd_bit;
            next_rdata[CTL_WR]    = wr_bit;
            next_rdata[CTL_WRITE_ENABLE_BIT]  = write_enable_bit;
            next_rdata[CTL_ERASE] = erase_sel;
            next_rdata[CTL_LATCH] = latch_only_select;
        end else if (S_AXI_ARADDR_I == OFS_UNLOCK) begin
            next_rdata = 32'h0000_0000;
        end else if (S_AXI_ARADDR_I == OFS_STATUS) begin
            next_rdata[STS_BUSY]  = busy;
            next_rdata[STS_ARMED] = (ulk == UL_ARMED);
            next_rdata[STS_HALT]  = CPU_HALT_O;
            next_rdata[STS_HIPWR] = HIGH_POWER_O;
        end else begin
            next_rresp = RESP_SLVERR;
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_RDATA_O   <= 32'h0000_0000;
            S_AXI_RRESP_O   <= RESP_OKAY;
        end else if (S_AXI_ARREADY_O && S_AXI_ARVALID_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O  <= 1'b1;
            S_AXI_RDATA_O   <= next_rdata;
            S_AXI_RRESP_O   <= next_rresp;
        end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
            S_AXI_RVALID_O  <= 1'b0;
            S_AXI_ARREADY_O <= 1'b1;
        end
    end
    assign flash_addr_pair = {flash_addr_high, flash_addr_low};
    assign busy            = (state != ST_IDLE);
    always_comb begin
        case (write_protect_setting)
            2'b00:   wp_bound = WP_BOUND_ALL;
            2'b01:   wp_bound = WP_BOUND_HALF;
            2'b10:   wp_bound = WP_BOUND_LOW;
            default: wp_bound = WP_BOUND_NONE;
        endcase
    end
    // write strobe honoured only straight after 55h, AAh, with write-enable; for write protection the upper 4K shadows the lower 4K
    assign start_wr = wr_ctl & wdata[CTL_WR] & ~busy & wdata[CTL_WRITE_ENABLE_BIT]
                    & (ulk == UL_ARMED) & ~debugger_break
                    & ({1'b0, flash_addr_pair[ADDR_W-2:0]} >= wp_bound);
    assign start_rd = wr_ctl & wdata[CTL_RD] & ~busy & ~start_wr;
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            ulk <= UL_IDLE;
        end else if (debugger_break) begin
            ulk <= UL_IDLE;
        end else if (do_wr) begin
            if (wr_hit && waddr == OFS_UNLOCK && wdata[7:0] == UNLOCK_KEY1) begin
                ulk <= UL_KEY1;
            end else if (wr_hit && waddr == OFS_UNLOCK && wdata[7:0] == UNLOCK_KEY2 && ulk == UL_KEY1) begin
                ulk <= UL_ARMED;
            end else begin
                ulk <= UL_IDLE;
            end
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            flash_addr_low  <= '0;
            flash_addr_high <= '0;
            flash_data_low  <= '0;
            flash_data_high <= '0;
        end else begin
            if (wr_hit && waddr == OFS_ADDR_LOW) begin
                flash_addr_low <= wdata[7:0];
            end
            if (wr_hit && waddr == OFS_ADDR_HIGH) begin
                flash_addr_high <= wdata[4:0];
            end
            if (state == ST_RD2) begin
                {flash_data_high, flash_data_low} <= PM_RDATA_I;
            end else begin
                if (wr_hit && waddr == OFS_DATA_LOW) begin
                    flash_data_low <= wdata[7:0];
                end
                if (wr_hit && waddr == OFS_DATA_HIGH) begin
                    flash_data_high <= wdata[5:0];
                end
            end
        end
    end
    // control bits; strobes cannot be cleared by software
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            rd_bit            <= RST_BIT;
            wr_bit            <= RST_BIT;
            write_enable_bit  <= RST_BIT;
            erase_sel         <= RST_BIT;
            latch_only_select <= RST_BIT;
        end else begin
            if (wr_ctl && !busy) begin
                write_enable_bit  <= wdata[CTL_WRITE_ENABLE_BIT];
                erase_sel         <= wdata[CTL_ERASE];
                latch_only_select <= wdata[CTL_LATCH];
            end
            if (start_rd) begin
                rd_bit <= 1'b1;
            end else if (state == ST_RD2) begin
                rd_bit <= 1'b0;
            end
            if (start_wr) begin
                wr_bit <= 1'b1;
            end else if ((state == ST_SET2 && op_latch) || (state == ST_WAIT && timer == PROG_CYCLES - 1)) begin
                wr_bit <= 1'b0;
            end
        end
    end
    // row buffer latches, indexed by low address bits so loads wrap
    always_ff @(posedge CORE_CLK_I) begin
        if (start_wr && !wdata[CTL_ERASE]) begin
            row_buf[flash_addr_low[IDX_W-1:0]] <= {flash_data_high, flash_data_low};
        end
    end
    always_ff @(posedge CORE_CLK_I) begin
        if (!RESETN_I) begin
            state        <= ST_IDLE;
            op_latch     <= RST_BIT;
            op_erase     <= RST_BIT;
            row          <= '0;
            idx          <= '0;
            timer        <= '0;
            PM_ADDR_O    <= '0;
            PM_RD_O      <= RST_BIT;
            PM_WE_O      <= RST_BIT;
            PM_WDATA_O   <= '0;
            PM_ERASE_O   <= RST_BIT;
            NOP_FORCE_O  <= RST_BIT;
            CPU_HALT_O   <= RST_BIT;
            HIGH_POWER_O <= RST_BIT;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_wr) begin
                        state        <= ST_SET1;
                        op_latch     <= wdata[CTL_LATCH];
                        op_erase     <= wdata[CTL_ERASE];
                        row          <= flash_addr_pair[ADDR_W-1:IDX_W];
                        NOP_FORCE_O  <= 1'b1;
                        HIGH_POWER_O <= 1'b1;
                    end else if (start_rd) begin
                        state       <= ST_RD1;
                        PM_ADDR_O   <= flash_addr_pair;
                        PM_RD_O     <= 1'b1;
                        NOP_FORCE_O <= 1'b1;
                    end
                end
                ST_RD1: begin
                    PM_RD_O <= 1'b0;
                    state   <= ST_RD2;
                end
                ST_RD2: begin
                    NOP_FORCE_O <= 1'b0;
                    state       <= ST_IDLE;
                end
                ST_SET1: state <= ST_SET2;
                ST_SET2: begin
                    NOP_FORCE_O <= 1'b0;
                    if (op_latch) begin
                        state        <= ST_IDLE;
                        HIGH_POWER_O <= 1'b0;
                    end else if (op_erase) begin
                        state      <= ST_ERASE;
                        PM_ERASE_O <= 1'b1;
                        PM_ADDR_O  <= {row, {IDX_W{1'b0}}};
                        CPU_HALT_O <= 1'b1;
                    end else begin
                        state      <= ST_PROG;
                        idx        <= '0;
                        PM_WE_O    <= 1'b1;
                        PM_ADDR_O  <= {row, {IDX_W{1'b0}}};
                        PM_WDATA_O <= row_buf[0];
                        CPU_HALT_O <= 1'b1;
                    end
                end
                ST_ERASE: begin
                    PM_ERASE_O <= 1'b0;
                    timer      <= '0;
                    state      <= ST_WAIT;
                end
                ST_PROG: begin
                    if (idx == IDX_W'(ROW_WORDS - 1)) begin
                        PM_WE_O <= 1'b0;
                        timer   <= '0;
                        state   <= ST_WAIT;
                    end else begin
                        idx        <= idx + 1'b1;
                        PM_ADDR_O  <= {row, idx + 1'b1};
                        PM_WDATA_O <= row_buf[idx + 1'b1];
                    end
                end
                ST_WAIT: begin
                    if (timer == PROG_CYCLES - 1) begin
                        state        <= ST_IDLE;
                        CPU_HALT_O   <= 1'b0;
                        HIGH_POWER_O <= 1'b0;
                    end else begin
                        timer <= timer + 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // pfc_flash_ctrl

/* verilog/pfc_pkg.sv */
package pfc_pkg;
    localparam int ADDR_W    = 13;
    localparam int DATA_W    = 14;
    localparam int IDX_W     = 5;
    localparam int ROW_WORDS = 32;
    localparam int ROW_W     = ADDR_W - IDX_W;
    localparam int AXI_AW    = 8;

    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL   = 8'h10;
    localparam logic [7:0] OFS_UNLOCK    = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    localparam int CTL_RD    = 0;
    localparam int CTL_WR    = 1;
    localparam int CTL_WRITE_ENABLE_BIT  = 2;
    localparam int CTL_ERASE = 4;
    localparam int CTL_LATCH = 5;
    localparam int STS_BUSY  = 0;
    localparam int STS_ARMED = 1;
    localparam int STS_HALT  = 2;
    localparam int STS_HIPWR = 3;

    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic       RST_BIT     = 1'b0;

    // lowest unprotected address per write-protect setting
    localparam logic [ADDR_W-1:0] WP_BOUND_ALL  = 13'h1000;
    localparam logic [ADDR_W-1:0] WP_BOUND_HALF = 13'h0800;
    localparam logic [ADDR_W-1:0] WP_BOUND_LOW  = 13'h0200;
    localparam logic [ADDR_W-1:0] WP_BOUND_NONE = 13'h0000;

    localparam int PROG_TIME_NS     = 2000000;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD1, ST_RD2, ST_SET1, ST_SET2, ST_ERASE, ST_PROG, ST_WAIT
    } pfc_state_e;

    typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_ARMED} pfc_unlock_e;
endpackage

/* tb/pfc_flash_ctrl_checker.sv */
`timescale 1ns/1ps
module pfc_flash_ctrl_checker
    import pfc_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = 8
) (
    input wire logic              CORE_CLK_I,
    input wire logic              RESETN_I,
    input wire logic [ADDR_W-1:0] PM_ADDR_O,
    input wire logic              PM_RD_O,
    input wire logic              PM_WE_O,
    input wire logic              PM_ERASE_O,
    input wire logic              NOP_FORCE_O,
    input wire logic              CPU_HALT_O,
    input wire logic              HIGH_POWER_O,
    input wire logic              CODE_PROTECT_I,
    input wire logic              EXT_PROG_EN_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    logic [5:0]        we_run;
    logic [31:0]       halt_run;
    logic [ADDR_W-1:0] addr_q;
    // length of the current program burst
    always_ff @(posedge CORE_CLK_I) begin
        we_run <= (!RESETN_I || !PM_WE_O) ? 6'h00 : we_run + 6'h01;
    end
    always_ff @(posedge CORE_CLK_I) begin
        halt_run <= (!RESETN_I || !CPU_HALT_O) ? 32'h0 : halt_run + 32'h1;
    end
    always_ff @(posedge CORE_CLK_I) begin
        addr_q <= PM_ADDR_O;
    end
    rd_nop_a: assert property (PM_RD_O |-> NOP_FORCE_O ##1 (NOP_FORCE_O && !PM_RD_O) ##1 !NOP_FORCE_O)
        else $error("read strobe slot forcing wrong");
    wr_nop_a: assert property ($rose(HIGH_POWER_O) |-> NOP_FORCE_O ##1 NOP_FORCE_O ##1 !NOP_FORCE_O)
        else $error("write strobe slot forcing wrong");
    we_start_a: assert property ($rose(PM_WE_O) |-> PM_ADDR_O[4:0] == 5'h00)
        else $error("row program not starting at row base");
    we_row_a: assert property (PM_WE_O && $past(PM_WE_O) |->
        PM_ADDR_O[12:5] == addr_q[12:5] && PM_ADDR_O[4:0] == addr_q[4:0] + 5'h01)
        else $error("program address not stepping inside row");
    we_len_a: assert property ($fell(PM_WE_O) |-> we_run == 6'h20)
        else $error("program burst not 32 words");
    we_power_a: assert property (PM_WE_O |-> HIGH_POWER_O && CPU_HALT_O)
        else $error("program without high power or halt");
    erase_row_a: assert property (PM_ERASE_O |-> PM_ADDR_O[4:0] == 5'h00 && HIGH_POWER_O ##1 !PM_ERASE_O && CPU_HALT_O)
        else $error("erase pulse wrong");
    halt_len_a: assert property ($fell(CPU_HALT_O) |-> halt_run >= PROG_CYCLES)
        else $error("halt too short");
    cp_set_a: assert property (CODE_PROTECT_I [*4] |-> !EXT_PROG_EN_O)
        else $error("external access open under protection");
    cp_clr_a: assert property (!CODE_PROTECT_I [*4] |-> EXT_PROG_EN_O)
        else $error("external access closed without protection");
endmodule // pfc_flash_ctrl_checker

bind pfc_flash_ctrl pfc_flash_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) pfc_flash_ctrl_checker_i (
    .CORE_CLK_I(CORE_CLK_I), .RESETN_I(RESETN_I), .PM_ADDR_O(PM_ADDR_O), .PM_RD_O(PM_RD_O),
    .PM_WE_O(PM_WE_O), .PM_ERASE_O(PM_ERASE_O), .NOP_FORCE_O(NOP_FORCE_O), .CPU_HALT_O(CPU_HALT_O),
    .HIGH_POWER_O(HIGH_POWER_O), .CODE_PROTECT_I(CODE_PROTECT_I), .EXT_PROG_EN_O(EXT_PROG_EN_O));

/* tb/pfc_flash_ctrl_tb_top.sv */
`timescale 1ns/1ps
module pfc_flash_ctrl_tb_top
    import pfc_pkg::*;
;
    localparam int unsigned PC = 8;
    logic clk = 1'b0, rst_n = 1'b0, cp = 1'b0, dbg = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, last_rd;
    logic [1:0] wp = 2'b11, bresp, rresp;
    logic [DATA_W-1:0] pm_rdata = 14'h0, pm_wdata;
    logic awready, wready, bvalid, arready, rvalid, pm_rd, pm_we, pm_erase, nop_f, halt, hipwr, ext_en;
    logic [ADDR_W-1:0] pm_addr, rd_addr, er_addr;
    logic [7:0] we_row;
    logic [34:0] rq[$];
    logic [1:0] bq[$];
    logic [DATA_W-1:0] exp_row[32], got_row[32];
    int error_cnt = 0, total_checks = 0, we_cnt = 0, er_cnt = 0, rd_cnt = 0;

    always #5 clk = ~clk;

    pfc_flash_ctrl #(.PROG_CYCLES(PC)) pfc_flash_ctrl_i (
        .CORE_CLK_I(clk), .RESETN_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .PM_ADDR_O(pm_addr), .PM_RD_O(pm_rd), .PM_RDATA_I(pm_rdata), .PM_WE_O(pm_we),
        .PM_WDATA_O(pm_wdata), .PM_ERASE_O(pm_erase), .NOP_FORCE_O(nop_f), .CPU_HALT_O(halt),
        .HIGH_POWER_O(hipwr), .WRITE_PROTECT_I(wp), .CODE_PROTECT_I(cp), .DEBUG_BREAK_I(dbg),
        .EXT_PROG_EN_O(ext_en));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // result monitor and array-side recorders
    always @(posedge clk) begin
        if (rvalid && rready) begin
            if (rq[0][34])
                check("rdata", rdata, rq[0][31:0]);
            check("rresp", {30'h0, rresp}, {30'h0, rq[0][33:32]});
            void'(rq.pop_front());
        end
        if (bvalid && bready)
            check("bresp", {30'h0, bresp}, {30'h0, bq.pop_front()});
        if (pm_rd) begin
            rd_cnt++;
            rd_addr = pm_addr;
        end
        if (pm_erase) begin
            er_cnt++;
            er_addr = pm_addr;
        end
        if (pm_we) begin
            we_cnt++;
            we_row = pm_addr[12:5];
            got_row[pm_addr[4:0]] = pm_wdata;
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && n < 40);
        bready <= 1'b0;
        if (n >= 40)
            error_cnt++;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic c = 1'b1,
                          input logic [1:0] er = RESP_OKAY);
        int n;
        n = 0;
        rq.push_back({c, er, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready)
                arvalid <= 1'b0;
            last_rd = rdata;
        end while (!rvalid && n < 40);
        rready <= 1'b0;
        if (n >= 40)
            error_cnt++;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            axi_rd(OFS_STATUS, 32'h0, 1'b0);
            n++;
        end while (last_rd[STS_BUSY] !== 1'b0 && n < 60);
        if (n >= 60)
            error_cnt++;
    endtask

    task automatic load(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        axi_wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
        axi_wr(OFS_ADDR_HIGH, {27'h0, a[12:8]});
        axi_wr(OFS_DATA_LOW, {24'h0, d[7:0]});
        axi_wr(OFS_DATA_HIGH, {26'h0, d[13:8]});
    endtask

    // unlock pair, optional debugger break, then control write
    task automatic strobe(input logic [7:0] ctl, input logic brk = 1'b0);
        axi_wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY1});
        axi_wr(OFS_UNLOCK, {24'h0, UNLOCK_KEY2});
        if (brk) begin
            dbg <= 1'b1;
            repeat (4) @(posedge clk);
            dbg <= 1'b0;
        end
        axi_wr(OFS_CONTROL, {24'h0, ctl});
        wait_idle();
    endtask

    initial begin
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] w;
        void'($urandom(65853));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axi_rd(OFS_CONTROL, 32'h0);
        axi_wr(8'h1C, 32'h0, RESP_SLVERR);
        axi_rd(8'h1C, 32'h0, 1'b0, RESP_SLVERR);
        axi_wr(OFS_UNLOCK, 32'h55);
        axi_rd(OFS_UNLOCK, 32'h0);
        $display("test registers done");
        w = DATA_W'($urandom);
        a = ADDR_W'($urandom);
        pm_rdata <= w;
        cp <= 1'b1;
        load(a, 14'h0);
        axi_rd(OFS_ADDR_LOW, {24'h0, a[7:0]});
        axi_rd(OFS_ADDR_HIGH, {27'h0, a[12:8]});
        axi_wr(OFS_CONTROL, 32'h01);
        wait_idle();
        pm_rdata <= ~w;
        check("rd_cnt", rd_cnt, 1);
        check("rd_addr", {19'h0, rd_addr}, {19'h0, a});
        axi_rd(OFS_DATA_LOW, {24'h0, w[7:0]});
        axi_rd(OFS_DATA_HIGH, {26'h0, w[13:8]});
        axi_rd(OFS_CONTROL, 32'h0);
        check("ext_en", {31'h0, ext_en}, 32'h0);
        cp <= 1'b0;
        repeat (5) @(posedge clk);
        check("ext_en", {31'h0, ext_en}, 32'h1);
        $display("test read done");
        load(13'h0A13, 14'h0);
        axi_wr(OFS_CONTROL, 32'h16);
        wait_idle();
        strobe(8'h16, 1'b1);
        strobe(8'h12);
        wp <= 2'b01;
        load(13'h0113, 14'h0);
        strobe(8'h16);
        wp <= 2'b00;
        load(13'h0A13, 14'h0);
        strobe(8'h16);
        check("refused", er_cnt + we_cnt, 0);
        axi_rd(OFS_CONTROL, 32'h14);
        wp <= 2'b11;
        load(13'h0A13, 14'h0);
        strobe(8'h16);
        check("er_cnt", er_cnt, 1);
        check("er_addr", {19'h0, er_addr}, 32'h0A00);
        $display("test erase done");
        wp <= 2'b01;
        for (int i = 0; i < 32; i++) begin
            w = DATA_W'($urandom);
            exp_row[i] = w;
            load((i == 0) ? 13'h0BE0 : 13'h0A00 | ADDR_W'(i), w);
            strobe((i < 31) ? 8'h26 : 8'h06);
            if (i == 30)
                check("latch", we_cnt, 0);
        end
        check("we_cnt", we_cnt, 32);
        check("we_row", {24'h0, we_row}, 32'h50);
        check("no_erase", er_cnt, 1);
        for (int i = 0; i < 32; i++)
            check("row_word", {18'h0, got_row[i]}, {18'h0, exp_row[i]});
        $display("test program done");
        wrap_up();
    end

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule // pfc_flash_ctrl_tb_top
